// ==== design/shc_pkg.sv ====
// package for the serial host control register block
// Overview of operation
// - bit7 forces chip select high, else pin
// - bit6 bypasses pad glitch filter and slew
// - bit5 holds register address fixed per transaction
// - bit4 powers down auxiliary synthesiser
// - bit3 powers down video synthesiser
// - bit2 selects differential reference, resets one
// - bit1 gates logic clocks, mask may narrow
// - bit0 sleeps: gates clocks, analog off, maskable
package shc_pkg;
    localparam logic [7:0] SHC_OFS_CTRL_ONE  = 8'h00;
    localparam int         SHC_BIT_FORCE_SEL = 7;
    localparam int         SHC_BIT_PAD_BYP   = 6;
    localparam int         SHC_BIT_STEP_INH  = 5;
    localparam int         SHC_BIT_AUX_OFF   = 4;
    localparam int         SHC_BIT_VID_OFF   = 3;
    localparam int         SHC_BIT_REF_DIFF  = 2;
    localparam int         SHC_BIT_CLK_GATE  = 1;
    localparam int         SHC_BIT_SLEEP     = 0;
    localparam logic [7:0] SHC_RST_CTRL_ONE  = 8'h04;
    localparam logic [6:0] SHC_DEV_ADDR      = 7'h44;
endpackage

// ==== design/shc_reg_if.sv ====
// carrier between the serial engine and the register file
`timescale 1ns/1ps
`default_nettype none
interface shc_reg_if;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       step_inhibit;
    modport engine (output wr, output rd, output addr, output wdata,
                    input rdata, input step_inhibit);
    modport regs   (input wr, input rd, input addr, input wdata,
                    output rdata, output step_inhibit);
endinterface
`default_nettype wire

// ==== design/shc_regfile.sv ====
// control register one and its decoded outputs
`timescale 1ns/1ps
`default_nettype none
module shc_regfile
    import shc_pkg::*;
(
    // clock and reset
    input  wire logic  clk_sys,
    input  wire logic  resetn,
    // engine side
    shc_reg_if.regs    rb,
    // control outputs
    output logic [7:0] ctrl
);
    typedef struct packed {
        logic [7:0] ctrl;
    } shc_rf_t;
    shc_rf_t s, next_s;
    always_comb begin
        next_s = s;
        if (rb.wr && rb.addr == SHC_OFS_CTRL_ONE) begin
            next_s.ctrl = rb.wdata;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s.ctrl <= SHC_RST_CTRL_ONE;
        end else begin
            s <= next_s;
        end
    end
    // unmapped offsets read zero
    assign rb.rdata        = (rb.addr == SHC_OFS_CTRL_ONE) ? s.ctrl : 8'h00;
    assign rb.step_inhibit = s.ctrl[SHC_BIT_STEP_INH];
    assign ctrl            = s.ctrl;
endmodule // shc_regfile
`default_nettype wire

// ==== design/shc_top.sv ====
// serial host control: i2c slave engine plus control register one
`timescale 1ns/1ps
`default_nettype none
module shc_top
    import shc_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // serial pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic select_or_port_clock_pin,
    // clock gating and analog power mask inputs
    input  wire logic gate_fivefold_only,
    input  wire logic gate_video_only,
    input  wire logic [1:0] analog_keep_mask,
    // control outputs
    output logic      force_select_override,
    output logic      pad_filter_bypass,
    output logic      address_step_inhibit,
    output logic      aux_synth_off,
    output logic      video_synth_off,
    output logic      ref_differential,
    output logic      logic_clock_gate,
    output logic      sleep_mode,
    output logic      gate_system_clock,
    output logic      gate_video_clock,
    output logic      gate_fivefold_clock,
    output logic [1:0] analog_power_down,
    output logic      chip_select_eff
);
    import shc_pkg::*;

    typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_RACK, ST_WDAT, ST_WACK,
                  ST_RDAT, ST_RCHK} shc_st_t;
    typedef struct packed {
        logic [1:0] scl_sy;
        logic [1:0] sda_sy;
        logic [1:0] sel_sy;
        logic       scl_q;
        logic       sda_q;
        shc_st_t    st;
        logic [2:0] bitn;
        logic       full;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic       rnw;
        logic       drive_low;
        logic       wr;
        logic [7:0] wdata;
    } shc_s_t;

    shc_s_t     s, next_s;
    logic [7:0] ctrl;
    shc_reg_if  rb();

    ////////////////////////////////////////////////////////////////////////
    // register file, kept on the ungated system clock
    shc_regfile u_regs (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .rb      (rb),
        .ctrl    (ctrl)
    );

    ////////////////////////////////////////////////////////////////////////
    // serial engine
    logic scl, sda, scl_rise, scl_fall, start_c, stop_c, sel_ok;
    always_comb begin
        scl      = s.scl_sy[1];
        sda      = s.sda_sy[1];
        scl_rise = scl && !s.scl_q;
        scl_fall = !scl && s.scl_q;
        start_c  = scl && s.scl_q && s.sda_q && !sda;
        stop_c   = scl && s.scl_q && !s.sda_q && sda;
        sel_ok   = ctrl[SHC_BIT_FORCE_SEL] | s.sel_sy[1];
    end

    always_comb begin
        next_s        = s;
        next_s.scl_sy = {s.scl_sy[0], scl_in};
        next_s.sda_sy = {s.sda_sy[0], sda_in};
        next_s.sel_sy = {s.sel_sy[0], select_or_port_clock_pin};
        next_s.scl_q  = scl;
        next_s.sda_q  = sda;
        next_s.wr     = 1'b0;
        if (start_c) begin
            next_s.st        = ST_ADDR;
            next_s.bitn      = 3'h7;
            next_s.full      = 1'b0;
            next_s.drive_low = 1'b0;
        end else if (stop_c) begin
            next_s.st        = ST_IDLE;
            next_s.drive_low = 1'b0;
        end else begin
            case (s.st)
                ST_ADDR, ST_REG, ST_WDAT: begin
                    if (scl_rise) begin
                        next_s.sh   = {s.sh[6:0], sda};
                        next_s.bitn = s.bitn - 3'h1;
                        next_s.full = (s.bitn == 3'h0);
                    end
                    // byte taken on the fall after its eighth rise, never the start's fall
                    if (scl_fall && s.full) begin
                        next_s.full = 1'b0;
                        if (s.st == ST_ADDR) begin
                            if (s.sh[7:1] == SHC_DEV_ADDR && sel_ok) begin
                                next_s.rnw       = s.sh[0];
                                next_s.drive_low = 1'b1;
                                next_s.st        = ST_AACK;
                            end else begin
                                next_s.st = ST_IDLE;
                            end
                        end else if (s.st == ST_REG) begin
                            next_s.ptr       = s.sh;
                            next_s.drive_low = 1'b1;
                            next_s.st        = ST_RACK;
                        end else begin
                            next_s.wr        = 1'b1;
                            next_s.wdata     = s.sh;
                            next_s.drive_low = 1'b1;
                            next_s.st        = ST_WACK;
                        end
                    end
                end
                ST_AACK, ST_RACK, ST_WACK: begin
                    if (scl_fall) begin
                        next_s.drive_low = 1'b0;
                        next_s.bitn      = 3'h7;
                        if (s.st == ST_WACK && !rb.step_inhibit) begin
                            next_s.ptr = s.ptr + 8'h01;
                        end
                        if (s.st == ST_AACK && s.rnw) begin
                            next_s.sh        = rb.rdata;
                            next_s.drive_low = !rb.rdata[7];
                            next_s.st        = ST_RDAT;
                        end else if (s.st == ST_AACK) begin
                            next_s.st = ST_REG;
                        end else begin
                            next_s.st = ST_WDAT;
                        end
                    end
                end
                ST_RDAT: begin
                    if (scl_fall) begin
                        if (s.bitn == 3'h0) begin
                            next_s.drive_low = 1'b0;
                            next_s.st        = ST_RCHK;
                        end else begin
                            next_s.bitn      = s.bitn - 3'h1;
                            next_s.sh        = {s.sh[6:0], 1'b0};
                            next_s.drive_low = !s.sh[6];
                        end
                    end
                end
                ST_RCHK: begin
                    if (scl_rise) begin
                        if (sda) begin
                            next_s.st = ST_IDLE;
                        end else if (!rb.step_inhibit) begin
                            next_s.ptr = s.ptr + 8'h01;
                        end
                    end
                    if (scl_fall && s.st == ST_RCHK && !sda) begin
                        next_s.bitn      = 3'h7;
                        next_s.sh        = rb.rdata;
                        next_s.drive_low = !rb.rdata[7];
                        next_s.st        = ST_RDAT;
                    end
                end
                default: begin
                    next_s.st = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s <= '0;
            s.scl_sy <= 2'h3;
            s.sda_sy <= 2'h3;
            s.scl_q  <= 1'b1;
            s.sda_q  <= 1'b1;
            s.st     <= ST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign rb.wr    = s.wr;
    assign rb.rd    = (s.st == ST_RDAT);
    assign rb.addr  = s.ptr;
    assign rb.wdata = s.wdata;
    assign sda_out  = 1'b0;
    assign sda_oe   = s.drive_low;

    ////////////////////////////////////////////////////////////////////////
    // control outputs
    always_comb begin
        force_select_override = ctrl[SHC_BIT_FORCE_SEL];
        chip_select_eff       = sel_ok;
        pad_filter_bypass     = ctrl[SHC_BIT_PAD_BYP];
        address_step_inhibit  = ctrl[SHC_BIT_STEP_INH];
        aux_synth_off         = ctrl[SHC_BIT_AUX_OFF] | ctrl[SHC_BIT_SLEEP];
        video_synth_off       = ctrl[SHC_BIT_VID_OFF] | ctrl[SHC_BIT_SLEEP];
        ref_differential      = ctrl[SHC_BIT_REF_DIFF];
        logic_clock_gate      = ctrl[SHC_BIT_CLK_GATE];
        sleep_mode            = ctrl[SHC_BIT_SLEEP];
        gate_fivefold_clock   = (ctrl[SHC_BIT_CLK_GATE] && !gate_video_only)
                                || ctrl[SHC_BIT_SLEEP];
        gate_video_clock      = (ctrl[SHC_BIT_CLK_GATE] && !gate_fivefold_only)
                                || ctrl[SHC_BIT_SLEEP];
        gate_system_clock     = (ctrl[SHC_BIT_CLK_GATE] && !gate_fivefold_only
                                && !gate_video_only) || ctrl[SHC_BIT_SLEEP];
        analog_power_down     = {2{ctrl[SHC_BIT_SLEEP]}} & ~analog_keep_mask;
    end
endmodule // shc_top
`default_nettype wire

// ==== tb/shc_checker.sv ====
// assertions on the serial host control block ports
`timescale 1ns/1ps
`default_nettype none
module shc_checker
    import shc_pkg::*;
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       resetn,
    // serial pins
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       select_or_port_clock_pin,
    // power control inputs
    input wire logic       gate_fivefold_only,
    input wire logic       gate_video_only,
    input wire logic [1:0] analog_keep_mask,
    // control outputs
    input wire logic [1:0] analog_power_down,
    input wire logic       force_select_override,
    input wire logic       pad_filter_bypass,
    input wire logic       address_step_inhibit,
    input wire logic       aux_synth_off,
    input wire logic       video_synth_off,
    input wire logic       ref_differential,
    input wire logic       logic_clock_gate,
    input wire logic       sleep_mode,
    input wire logic       gate_system_clock,
    input wire logic       gate_video_clock,
    input wire logic       gate_fivefold_clock,
    input wire logic       chip_select_eff
);
    wire logic [7:0] bits = {force_select_override, pad_filter_bypass, address_step_inhibit,
        aux_synth_off, video_synth_off, ref_differential, logic_clock_gate, sleep_mode};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence pin_low; (!select_or_port_clock_pin && !force_select_override) [*6]; endsequence
    sequence scl_quiet; scl_in [*8]; endsequence
    force_sel_a: assert property (force_select_override |-> chip_select_eff)
        else $error("select not forced");
    pin_low_a: assert property (pin_low |-> !chip_select_eff)
        else $error("select high with pin low");
    reset_val_a: assert property ($rose(resetn) |-> bits == SHC_RST_CTRL_ONE && !sda_oe)
        else $error("bad reset value");
    sleep_synth_a: assert property (sleep_mode |-> aux_synth_off && video_synth_off)
        else $error("synth on in sleep");
    analog_off_a: assert property ($stable({sleep_mode, analog_keep_mask})
        |-> analog_power_down == ({2{sleep_mode}} & ~analog_keep_mask)) else $error("analog");
    gate_all_a: assert property (logic_clock_gate && !gate_fivefold_only && !gate_video_only
        && $stable({logic_clock_gate, gate_fivefold_only, gate_video_only})
        |-> gate_system_clock && gate_video_clock && gate_fivefold_clock) else $error("gate");
    gate_idle_a: assert property (!logic_clock_gate && !sleep_mode
        && $stable({logic_clock_gate, sleep_mode})
        |-> !(gate_system_clock || gate_video_clock || gate_fivefold_clock)) else $error("idle");
    bits_hold_a: assert property (scl_quiet |=> $stable(bits))
        else $error("bits moved without traffic");
    open_drain_a: assert property (!sda_out)
        else $error("sda driven high");
endmodule // shc_checker
bind shc_top shc_checker i_chk (.*);
`default_nettype wire

// ==== tb/shc_i2c_host.sv ====
// i2c host model for the serial pins
`timescale 1ns/1ps
`default_nettype none
module shc_i2c_host (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        #16 scl = 1'b1;
        #16 r = sda;
        #16 scl = 1'b0;
        #16;
    endtask
    task automatic start();
        sda_low = 1'b0;
        #16 scl = 1'b1;
        #32 sda_low = 1'b1;
        #32 scl = 1'b0;
        #16;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        #16 scl = 1'b1;
        #32 sda_low = 1'b0;
        #32;
    endtask
    // byte msb first, ninth bit is the acknowledge
    task automatic xbyte(input logic [7:0] d, input logic rel, output logic [7:0] q,
                         output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(rel, ack);
        ack = ~ack;
    endtask
endmodule // shc_i2c_host
`default_nettype wire

// ==== tb/shc_top_bench.sv ====
// self-checking bench for the serial host control block
`timescale 1ns/1ps
`default_nettype none
module shc_top_bench;
    import shc_pkg::*;
    logic clk_sys, resetn, scl_in, sda_low, sda_out, sda_oe, select_or_port_clock_pin, ack;
    logic gate_fivefold_only, gate_video_only, force_select_override, pad_filter_bypass;
    logic address_step_inhibit, aux_synth_off, video_synth_off, ref_differential;
    logic logic_clock_gate, sleep_mode, gate_system_clock, gate_video_clock;
    logic gate_fivefold_clock, chip_select_eff;
    logic [1:0] analog_keep_mask, analog_power_down;
    logic [7:0] m, q;
    int miscompares, n_compared, ptr;
    wire logic sda_in = ~(sda_low | (sda_oe & ~sda_out));
    wire logic [7:0] ctl = {force_select_override, pad_filter_bypass, address_step_inhibit,
        aux_synth_off, video_synth_off, ref_differential, logic_clock_gate, sleep_mode};
    shc_top i_dut (.*);
    shc_i2c_host i_host (.scl(scl_in), .sda_low(sda_low), .sda(sda_in));
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic outs();
        chk("ctrl", {m[7:5], m[4] | m[0], m[3] | m[0], m[2:0]}, ctl);
        chk("select", {7'h0, m[7] | select_or_port_clock_pin}, {7'h0, chip_select_eff});
        chk("analog", {6'h0, {2{m[0]}} & ~analog_keep_mask}, {6'h0, analog_power_down});
        if (!gate_fivefold_only && !gate_video_only)
            chk("gates", {5'h0, {3{m[1] | m[0]}}}, {5'h0, gate_system_clock, gate_video_clock,
                gate_fivefold_clock});
        else if (gate_fivefold_only != gate_video_only)
            chk("narrow", {5'h0, m[0], (m[1] & gate_video_only) | m[0],
                (m[1] & gate_fivefold_only) | m[0]}, {5'h0, gate_system_clock,
                gate_video_clock, gate_fivefold_clock});
    endtask
    task automatic wr(input logic [6:0] a, input int off, n, input logic [7:0] d0, d1);
        logic sel;
        sel = (m[7] | select_or_port_clock_pin) && a == SHC_DEV_ADDR;
        i_host.start();
        i_host.xbyte({a, 1'b0}, 1'b1, q, ack);
        chk("addr ack", {7'h0, sel}, {7'h0, ack});
        if (sel) begin
            i_host.xbyte(off[7:0], 1'b1, q, ack);
            ptr = off;
            for (int i = 0; i < n; i++) begin
                i_host.xbyte(i ? d1 : d0, 1'b1, q, ack);
                if (ptr == 0) m = i ? d1 : d0;
                if (!m[5]) ptr++;
            end
        end
        i_host.stop();
    endtask
    task automatic rd(input int n);
        i_host.start();
        i_host.xbyte({SHC_DEV_ADDR, 1'b1}, 1'b1, q, ack);
        for (int i = 0; i < n; i++) begin
            i_host.xbyte(8'hff, i == n - 1, q, ack);
            chk("read", ptr == 0 ? m : 8'h00, q);
            if (!m[5]) ptr++;
        end
        i_host.stop();
    endtask
    task automatic results();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        #300000;
        miscompares++;
        results();
    end
    initial begin
        resetn = 1'b0;
        {select_or_port_clock_pin, gate_fivefold_only, gate_video_only, analog_keep_mask} = 5'h10;
        m = SHC_RST_CTRL_ONE;
        void'($urandom(54));
        repeat (5) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        outs();
        wr(SHC_DEV_ADDR, 0, 0, 0, 0);
        rd(2);
        for (int k = 0; k < 14; k++) begin
            @(posedge clk_sys);
            #1 {select_or_port_clock_pin, gate_fivefold_only, gate_video_only,
                analog_keep_mask} = 5'($urandom);
            wr(SHC_DEV_ADDR, 0, 1, k < 2 ? {8{k[0]}} : 8'($urandom), 0);
            outs();
            select_or_port_clock_pin = 1'b1;
            wr(SHC_DEV_ADDR, 0, 0, 0, 0);
            rd(1);
        end
        for (int k = 0; k < 2; k++) begin
            wr(SHC_DEV_ADDR, 0, 1, {2'b0, k[0], 5'h0}, 0);
            wr(SHC_DEV_ADDR, 0, 2, k ? 8'h21 : 8'h12, k ? 8'h63 : 8'h5a);
            outs();
            wr(SHC_DEV_ADDR, 0, 0, 0, 0);
            rd(2);
        end
        wr(SHC_DEV_ADDR ^ 7'h01, 0, 1, 8'hff, 0);
        wr(SHC_DEV_ADDR, 5, 1, 8'hff, 0);
        outs();
        results();
    end
endmodule // shc_top_bench
`default_nettype wire
